// File: logic/nfc_defines.vh
// Format codes, field positions and reserved encodings of the number format converter
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH

// Source format selector
`define NFC_FMT_SHORT 2'h0
`define NFC_FMT_SINGLE 2'h1
`define NFC_FMT_EXT 2'h2
`define NFC_FMT_NONE 2'h3

// Integer widths
`define NFC_SHORT_W 16
`define NFC_INT_W 32
`define NFC_EXT_W 40

// Short float fields
`define NFC_SF_EXP_HI 15
`define NFC_SF_EXP_LO 12
`define NFC_SF_MAN_HI 11
`define NFC_SF_MAN_LO 0
`define NFC_SF_ZERO_EXP 4'h8

// Single float fields
`define NFC_SP_EXP_HI 31
`define NFC_SP_EXP_LO 24
`define NFC_SP_MAN_HI 23
`define NFC_SP_MAN_LO 0

// Extended float fields
`define NFC_XP_EXP_HI 39
`define NFC_XP_EXP_LO 32
`define NFC_XP_MAN_HI 31
`define NFC_XP_MAN_LO 0
`define NFC_XP_KEEP_LO 8

// Reserved zero of the 8-bit exponent formats
`define NFC_ZERO_EXP8 8'h80
`define NFC_SP_ZERO 32'h8000_0000
`define NFC_XP_ZERO 40'h80_0000_0000

`endif

// File: logic/nfc_int_ext.v
// Integer operand extension: short immediates and low word of extended registers
`timescale 1ns/10ps

module nfc_int_ext (
	// Sources
	input wire [15:0] imm16,
	input wire [39:0] reg40,
	input wire use_imm,
	input wire is_signed,
	// Formatted operand
	output wire [31:0] op32
);
`include "nfc_defines.vh"

	wire [31:0] imm_sext;
	wire [31:0] imm_zext;

	assign imm_sext = {{16{imm16[15]}}, imm16};
	assign imm_zext = {16'h0000, imm16};
	// Upper byte of the register never reaches the integer unit
	assign op32 = use_imm ? (is_signed ? imm_sext : imm_zext) : reg40[31:0];

endmodule

// File: logic/nfc_flt_conv.v
// Float operand conversion of one source to single and extended precision
`timescale 1ns/10ps

module nfc_flt_conv (
	// Source word and its format
	input wire [39:0] src,
	input wire [1:0] fmt,
	// Converted forms
	output reg [31:0] single32,
	output reg [39:0] ext40,
	output reg is_zero
);
`include "nfc_defines.vh"

	wire [3:0] sf_exp;
	wire [11:0] sf_man;
	wire [7:0] sf_exp8;
	wire [31:0] sp_word;

	assign sf_exp = src[`NFC_SF_EXP_HI:`NFC_SF_EXP_LO];
	assign sf_man = src[`NFC_SF_MAN_HI:`NFC_SF_MAN_LO];
	assign sf_exp8 = {{4{sf_exp[3]}}, sf_exp};
	assign sp_word = src[31:0];

	always @* begin
		single32 = `NFC_SP_ZERO;
		ext40 = `NFC_XP_ZERO;
		is_zero = 1'b1;
		case (fmt)
			`NFC_FMT_SHORT: begin
				// Most negative exponent alone marks zero
				is_zero = (sf_exp == `NFC_SF_ZERO_EXP);
				if (!is_zero) begin
					single32 = {sf_exp8, sf_man, 12'h000};
					ext40 = {sf_exp8, sf_man, 20'h0_0000};
				end
			end
			`NFC_FMT_SINGLE: begin
				is_zero = (sp_word[`NFC_SP_EXP_HI:`NFC_SP_EXP_LO] == `NFC_ZERO_EXP8);
				single32 = sp_word;
				// A sign-extended -8 would not be zero here, so zeros are rebuilt
				if (!is_zero) begin
					ext40 = {sp_word, 8'h00};
				end
			end
			`NFC_FMT_EXT: begin
				is_zero = (src[`NFC_XP_EXP_HI:`NFC_XP_EXP_LO] == `NFC_ZERO_EXP8);
				ext40 = src;
				// Plain truncation, no rounding
				single32 = src[`NFC_XP_EXP_HI:`NFC_XP_KEEP_LO];
			end
			default: begin
				is_zero = 1'b1;
			end
		endcase
	end

endmodule

// File: logic/nfc_top.v
// Operand formatting datapath: integer extension and float format conversion
`timescale 1ns/10ps

// What this block does
// - signed short immediate sign-extended to 32
// - extended registers as integers use bits 31-0
// - unsigned short immediate zero-filled to 32
// - 32-bit signed integer is two's complement
// - float: exponent, sign, fraction, implied nonsign bit
// - value 01.f or 10.f; min exponent zero
// - short float 4/1/11, exponent -8 zero
// - short float point between bits 11, 10
// - single float 8-bit exponent, sign, 23 fraction
// - single float point between bits 23, 22
// - extended float exponent 39-32, 31-bit fraction
// - extended float point between bits 31, 30
// - short to single: extend, copy, clear 11-0
// - short to extended: extend, copy, clear 19-0
// - single to extended: copy, clear 7-0
// - extended to single: drop 7-0, no rounding
// - widened zero becomes wider reserved zero
// - conversions add no cycles to operations
// - multiplier gets single sources, extended product
// - zero in 8-bit exponent formats uses -128
module nfc_top (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Operand sources
	input wire [15:0] imm16,
	input wire [39:0] src_a,
	input wire [39:0] src_b,
	input wire [1:0] fmt_a,
	input wire [1:0] fmt_b,
	input wire imm_a,
	input wire imm_b,
	input wire int_signed,
	// Results coming back from the arithmetic units
	input wire [31:0] int_result,
	input wire [39:0] dst_old,
	input wire [39:0] mul_product,
	input wire [39:0] flt_result,
	// Operands to the arithmetic units
	output wire [31:0] int_op_a,
	output wire [31:0] int_op_b,
	output wire [31:0] mul_op_a,
	output wire [31:0] mul_op_b,
	output wire [39:0] add_op_a,
	output wire [39:0] add_op_b,
	output wire signed [31:0] int_val_a,
	// Write-back values
	output wire [39:0] int_dst_new,
	output wire [39:0] mul_dst_new,
	output wire [31:0] flt_single_out,
	// Registered status
	output reg zero_a_r,
	output reg zero_b_r,
	output reg fmt_bad_r,
	output reg [1:0] ovf_sign_r
);
`include "nfc_defines.vh"

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function is_zero8;
		input [7:0] exp8;
		begin
			is_zero8 = (exp8 == `NFC_ZERO_EXP8);
		end
	endfunction

	function fmt_ok;
		input [1:0] fmt;
		begin
			fmt_ok = (fmt != `NFC_FMT_NONE);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Per-source conversion, purely combinational so no cycle is added

	wire [39:0] src_w [0:1];
	wire [1:0] fmt_w [0:1];
	wire imm_w [0:1];
	wire [31:0] int_w [0:1];
	wire [31:0] sp_w [0:1];
	wire [39:0] xp_w [0:1];
	wire zero_w [0:1];

	assign src_w[0] = src_a;
	assign src_w[1] = src_b;
	assign fmt_w[0] = fmt_a;
	assign fmt_w[1] = fmt_b;
	assign imm_w[0] = imm_a;
	assign imm_w[1] = imm_b;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_src
			nfc_int_ext u_int (
				.imm16(imm16),
				.reg40(src_w[gi]),
				.use_imm(imm_w[gi]),
				.is_signed(int_signed),
				.op32(int_w[gi])
			);
			nfc_flt_conv u_flt (
				.src(src_w[gi]),
				.fmt(fmt_w[gi]),
				.single32(sp_w[gi]),
				.ext40(xp_w[gi]),
				.is_zero(zero_w[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Operands out

	// Operand timing follows the sources directly; registering would cost a cycle
	assign int_op_a = int_w[0];
	assign int_op_b = int_w[1];
	assign int_val_a = int_w[0];
	// Multiplier always sees single precision, whatever the source
	assign mul_op_a = sp_w[0];
	assign mul_op_b = sp_w[1];
	// Adder works in extended precision; zeros arrive as exponent -128
	assign add_op_a = xp_w[0];
	assign add_op_b = xp_w[1];

	////////////////////////////////////////////////////////////////////////
	// Write-back

	assign int_dst_new = {dst_old[39:32], int_result};
	// Product kept extended; a zero mantissa forces the reserved exponent
	assign mul_dst_new = (mul_product[31:0] == 32'h0000_0000 && !mul_product[31]) ?
		`NFC_XP_ZERO : mul_product;
	assign flt_single_out = flt_result[39:8];

	////////////////////////////////////////////////////////////////////////
	// Status for observation, one cycle behind the operands

	reg zero_a_nxt;
	reg zero_b_nxt;
	reg fmt_bad_nxt;
	reg [1:0] ovf_sign_nxt;

	always @* begin
		zero_a_nxt = zero_w[0] && !imm_a;
		zero_b_nxt = zero_w[1] && !imm_b;
		fmt_bad_nxt = !fmt_ok(fmt_a) || !fmt_ok(fmt_b);
		// Sign bit of each nonzero single operand, as seen by the multiplier; zero operands give 0
		ovf_sign_nxt = {sp_w[1][23] && !is_zero8(sp_w[1][31:24]),
			sp_w[0][23] && !is_zero8(sp_w[0][31:24])};
	end

	always @(posedge clk) begin
		if (reset) begin
			zero_a_r <= 1'b0;
			zero_b_r <= 1'b0;
			fmt_bad_r <= 1'b0;
			ovf_sign_r <= 2'h0;
		end else begin
			zero_a_r <= zero_a_nxt;
			zero_b_r <= zero_b_nxt;
			fmt_bad_r <= fmt_bad_nxt;
			ovf_sign_r <= ovf_sign_nxt;
		end
	end

endmodule

// File: tb/nfc_top_sva.sv
// Assertion checker for the operand formatting datapath
`timescale 1ns/10ps
module nfc_top_sva (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Watched ports
	input wire [15:0] imm16,
	input wire [39:0] src_a,
	input wire [1:0] fmt_a,
	input wire imm_a,
	input wire int_signed,
	input wire [31:0] int_result,
	input wire [39:0] dst_old,
	input wire [31:0] int_op_a,
	input wire [31:0] mul_op_a,
	input wire [39:0] add_op_a,
	input wire [39:0] int_dst_new,
	input wire zero_a_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire sh_src = fmt_a == 2'h0 && src_a[15:12] != 4'h8;
	// Zero source seen first, flag follows one edge later
	sequence zero_src;
		!imm_a && (fmt_a == 2'h0 && src_a[15:12] == 4'h8 || fmt_a == 2'h2 && src_a[39:32] == 8'h80);
	endsequence
	sign_ext_a: assert property (imm_a && int_signed |-> int_op_a == {{16{imm16[15]}}, imm16})
		else $error("sign extension wrong");
	zero_fill_a: assert property (imm_a && !int_signed |-> int_op_a == {16'h0000, imm16})
		else $error("zero fill wrong");
	reg_low_a: assert property (!imm_a |-> int_op_a == src_a[31:0])
		else $error("register low word wrong");
	dst_keep_a: assert property (int_dst_new == {dst_old[39:32], int_result})
		else $error("upper destination bits changed");
	short_single_a: assert property (sh_src |-> mul_op_a == {{4{src_a[15]}}, src_a[15:0], 12'h000})
		else $error("short to single wrong");
	short_ext_a: assert property (sh_src |-> add_op_a == {{4{src_a[15]}}, src_a[15:0], 20'h0_0000})
		else $error("short to extended wrong");
	ext_single_a: assert property (fmt_a == 2'h2 |-> mul_op_a == src_a[39:8])
		else $error("extended to single wrong");
	zero_widen_a: assert property (fmt_a == 2'h0 && src_a[15:12] == 4'h8 |-> add_op_a == 40'h80_0000_0000)
		else $error("widened zero wrong");
	zero_flag_a: assert property (zero_src |=> zero_a_r)
		else $error("zero flag missing");
endmodule
bind nfc_top nfc_top_sva nfc_top_sva_inst (.clk, .reset, .imm16, .src_a, .fmt_a, .imm_a, .int_signed,
	.int_result, .dst_old, .int_op_a, .mul_op_a, .add_op_a, .int_dst_new, .zero_a_r);

// File: tb/nfc_arith_model.sv
// Behavioural model of the multiplier, adder and register file
`timescale 1ns/10ps
module nfc_arith_model (
	// Operands
	input wire [31:0] int_op_a,
	input wire [31:0] int_op_b,
	input wire [31:0] mul_op_a,
	input wire [39:0] add_op_a,
	input wire [39:0] reg_word,
	// Results
	output wire [31:0] int_result,
	output wire [39:0] dst_old,
	output wire [39:0] mul_product,
	output wire [39:0] flt_result
);
	assign int_result = int_op_a + int_op_b;
	assign dst_old = reg_word;
	// Raw product keeps a stale exponent on a cleared mantissa
	assign mul_product = {mul_op_a, 8'h00};
	assign flt_result = add_op_a;
endmodule

// File: tb/tb_nfc_top.sv
// Self-checking testbench of the operand formatting datapath
`timescale 1ns/10ps
module tb_nfc_top;
	reg clk = 0, reset = 1, imm_a = 0, imm_b = 0, int_signed = 0;
	reg [15:0] imm16 = 16'h0000;
	reg [39:0] src_a = 0, src_b = 0, reg_word = 0;
	reg [1:0] fmt_a = 0, fmt_b = 0;
	wire [31:0] int_op_a, int_op_b, mul_op_a, mul_op_b, int_result, flt_single_out;
	wire [39:0] add_op_a, add_op_b, int_dst_new, mul_dst_new, dst_old, mul_product, flt_result;
	wire zero_a_r, zero_b_r, fmt_bad_r;
	wire [1:0] ovf_sign_r;
	wire [31:0] int_val_a;
	integer n_mismatch = 0;
	integer checks = 0;
	nfc_top nfc_top_inst (.clk, .reset, .imm16, .src_a, .src_b, .fmt_a, .fmt_b, .imm_a, .imm_b, .int_signed,
		.int_result, .dst_old, .mul_product, .flt_result, .int_op_a, .int_op_b, .mul_op_a, .mul_op_b,
		.add_op_a, .add_op_b, .int_val_a, .int_dst_new, .mul_dst_new, .flt_single_out, .zero_a_r,
		.zero_b_r, .fmt_bad_r, .ovf_sign_r);
	nfc_arith_model nfc_arith_model_inst (.int_op_a, .int_op_b, .mul_op_a, .add_op_a, .reg_word,
		.int_result, .dst_old, .mul_product, .flt_result);
	initial forever #4 clk = ~clk;
	////////////////////////////////////////////////////////////
	task chk(input [39:0] got, input [39:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task results;
		begin
			$display("checks=%0d mismatches=%0d", checks, n_mismatch);
			if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////
	task t_integer;
		begin
			@(negedge clk);
			imm16 = 16'h8001;
			imm_a = 1;
			int_signed = 1;
			reg_word = 40'hA5_0000_0000;
			#1 chk(int_op_a, 32'hFFFF_8001);
			chk(int_val_a, 32'hFFFF_8001);
			chk(int_dst_new, 40'hA5_FFFF_8001);
			int_signed = 0;
			#1 chk(int_op_a, 32'h0000_8001);
			src_a = 40'h77_1234_5678;
			imm_a = 0;
			#1 chk(int_op_a, 32'h1234_5678);
		end
	endtask
	// Both sources carry the same word; zero flag judged one edge later
	task t_float(input [39:0] s, input [1:0] f, input [31:0] em, input [39:0] ea, input z);
		begin
			@(negedge clk);
			src_a = s;
			src_b = s;
			fmt_a = f;
			fmt_b = f;
			#1 chk(mul_op_a, em);
			chk(mul_op_b, em);
			chk(add_op_a, ea);
			chk(add_op_b, ea);
			chk(flt_single_out, ea[39:8]);
			chk(mul_dst_new, em[23:0] == 0 ? 40'h80_0000_0000 : {em, 8'h00});
			@(posedge clk);
			#1 chk(zero_a_r, z);
			chk(zero_b_r, z);
			chk(fmt_bad_r, f == 2'h3);
			// Sign bit of a nonzero single operand, both sources alike
			chk(ovf_sign_r, (em[23] && em[31:24] != 8'h80) ? 2'h3 : 2'h0);
		end
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk) reset = 0;
		t_integer;
		t_float(40'h1400, 2'h0, 32'h0140_0000, 40'h01_4000_0000, 0);
		t_float(40'hF7FF, 2'h0, 32'hFF7F_F000, 40'hFF_7FF0_0000, 0);
		t_float(40'h8000, 2'h0, 32'h8000_0000, 40'h80_0000_0000, 1);
		t_float(40'h1000, 2'h0, 32'h0100_0000, 40'h01_0000_0000, 0);
		t_float(40'h0540_0001, 2'h1, 32'h0540_0001, 40'h05_4000_0100, 0);
		t_float(40'h8012_3456, 2'h1, 32'h8012_3456, 40'h80_0000_0000, 1);
		t_float(40'h12_3456_78FF, 2'h2, 32'h1234_5678, 40'h12_3456_78FF, 0);
		t_float(40'h80_1234_5678, 2'h2, 32'h8012_3456, 40'h80_1234_5678, 1);
		t_float(40'hFF_F000_0000, 2'h2, 32'hFFF0_0000, 40'hFF_F000_0000, 0);
		t_float(40'h12_3456_78FF, 2'h3, 32'h8000_0000, 40'h80_0000_0000, 1);
		results;
	end
	initial begin
		repeat (1000) @(posedge clk);
		n_mismatch = n_mismatch + 1;
		results;
	end
endmodule
